// file: src/tdcr_pkg.sv
/*
  tdcr_pkg: constants, register map and configuration carrier of the
  two-channel stop capture block.
  assumes a single 10 MHz clock and word-aligned Avalon-MM registers.
*/
package tdcr_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ       = 10;    // core clock rate
  localparam int STOP_OPEN_NS  = 7;     // least start-to-stop acceptance
  localparam int PAUSE_NS      = 50;    // retrigger stamp insertion break
  // least time, rounded up, never below one cycle
  function automatic int ns_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int STOP_OPEN_CYC = ns_up(STOP_OPEN_NS);
  localparam int PAUSE_CYC     = ns_up(PAUSE_NS);
  // ==========================================================
  // widths and depths
  localparam int TS_W      = 23;        // result bits 22..0
  localparam int OFF_W     = 18;        // start offset width
  localparam int OFF_SCALE = 3;         // offset unit in bins
  localparam int HIT_DEPTH = 32;        // hit buffer per channel
  localparam int IF_DEPTH  = 256;       // output buffer per channel
  localparam int CNT_W     = 8;         // stop counter width
  localparam int BUS_W     = 28;        // wide data bus
  localparam int NARROW_W  = 16;        // narrow data bus
  localparam int FILL_W    = 9;         // load-level threshold width
  localparam int ADDR_W    = 6;         // byte address
  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [3:0] REG_ENABLE  = 4'h0;
  localparam logic [3:0] REG_DISABLE = 4'h2;
  localparam logic [3:0] REG_START   = 4'h5;
  localparam logic [3:0] REG_LEVEL   = 4'h6;
  localparam logic [3:0] REG_FIFO0   = 4'h8;
  localparam logic [3:0] REG_FIFO1   = 4'h9;
  localparam logic [3:0] REG_COUNT   = 4'hb;
  localparam logic [3:0] REG_MODE    = 4'hd;
  localparam logic [3:0] REG_WIDTH   = 4'he;
  localparam logic [31:0] WIDTH16_CODE = 32'h0000_0010;
  // ==========================================================
  // field positions
  localparam int EN_RISE_LSB = 0;       // start, stop0, stop1
  localparam int EN_FALL_LSB = 3;
  localparam int OFF_LSB     = 0;
  localparam int RETRIG_BIT  = 18;
  localparam int SINGLE_BIT  = 19;
  localparam int WAIT_BIT    = 20;
  localparam int FILL_LSB    = 0;
  localparam int POWER_BIT   = 16;
  localparam int QUIET_BIT   = 0;
  localparam int TRIG_BIT    = 1;
  localparam int CNT1_LSB    = 8;
  // ==========================================================
  // configuration carrier, all zero after reset
  typedef struct packed {
    logic [2:0]       rise_en;          // rising_edge_enables
    logic [2:0]       fall_en;          // falling_edge_enables
    logic [8:0]       sw_dis;           // triples: start, stop0, stop1
    logic [OFF_W-1:0] offset;           // start_offset_value
    logic             retrig;           // start_retrigger_enable
    logic             single;           // start_single_shot
    logic             wait_start;       // stops_wait_for_start
    logic [FILL_W-1:0] fill;            // load-level threshold
    logic             power;            // diff_buffer_power
    logic             quiet;            // quiet post-processing
    logic             narrow;           // 16-bit data bus
  } tdcr_cfg_type;
endpackage

// file: src/tdcr_sync.sv
/*
  tdcr_sync: two-flop synchroniser for a group of pin levels.
  assumes the inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/1ps
module tdcr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;                   // first stage, read by q_o only
  // ==========================================================
  // two-stage capture
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// file: src/tdcr_fifo.sv
/*
  tdcr_fifo: synchronous first-word-fall-through buffer.
  assumes nothing of the caller; a push when full or a pop when empty is ignored.
*/
`timescale 1ns/1ps
module tdcr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 push_i,
  input  wire logic [W-1:0]         din_i,
  input  wire logic                 pop_i,
  output logic      [W-1:0]         dout_o,
  output logic      [$clog2(DEPTH):0] count_o,
  output logic                      empty_o,
  output logic                      full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];           // storage
  logic [AW-1:0] wr_ptr;                // next write slot
  logic [AW-1:0] rd_ptr;                // head slot
  logic          do_push;
  logic          do_pop;
  assign do_push = push_i & ~full_o;
  assign do_pop  = pop_i & ~empty_o;
  assign empty_o = (count_o == '0);
  assign full_o  = (count_o == (AW+1)'(DEPTH));
  assign dout_o  = mem[rd_ptr];
  // ==========================================================
  // storage write, no reset needed on data
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[wr_ptr] <= din_i;
  end
  // ==========================================================
  // pointers and fill count
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_push & ~do_pop)
        count_o <= count_o + 1'b1;
      else if (do_pop & ~do_push)
        count_o <= count_o - 1'b1;
    end
  end
endmodule

// file: src/tdcr_top.sv
/*
  tdcr_top: two stop channels timed against one start, with hit buffers,
  offset-adding post-processing, output buffers and flags, Avalon-MM regs.
  assumes pins are asynchronous to clk_i and are synchronised here; the
  coarse stamp is the clk_i count, the fine delay line lies outside.
*/
`timescale 1ns/1ps
// Behaviour
// - two stop channels, one start, 32 hits
// - 8-bit rising-edge stop counters in register 11
// - separate edge enables; both clear disables channel
// - pin gates per edge; software disable triples
// - input buffers unpowered until power bit set
// - optional stop gating until start plus 7 ns
// - single start: only first start is reference unless retrigger is set
// - single-shot bit closes start after first pulse
// - add 18-bit offset times three to results
// - retrigger pauses post-processing for 50 ns
// - raw stop stamps enter per-channel hit buffers
// - pipelined subtraction into 256-entry output buffers
// - 28-bit bus, 16-bit after writing code 16 to register 14
// - output-enable low drives data bus continuously
// - empty and load-level flags, active high
// - level flag when count reaches shared threshold
// - quiet mode processes only after a trigger
// - non-quiet processes after start and a stop
// - output buffers read at registers 8 and 9
module tdcr_top
  import tdcr_pkg::*;
#(
  parameter int NCH       = 2,
  parameter int HIT_DEP   = tdcr_pkg::HIT_DEPTH,
  parameter int IF_DEP    = tdcr_pkg::IF_DEPTH
) (
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic [tdcr_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire logic                       start_pin_i,
  input  wire logic [1:0]                 diff_stop_input_i,
  input  wire logic                       start_gate_pin_i,
  input  wire logic [3:0]                 stop_gate_pin_i,
  input  wire logic                       alu_trigger_i,
  input  wire logic                       out_en_n_i,
  output logic      [tdcr_pkg::BUS_W-1:0] dbus_o,
  output logic                            dbus_oe_o,
  output logic                            diff_buffer_power_o,
  output logic      [1:0]                 buffer_empty_flag_o,
  output logic      [1:0]                 buffer_level_flag_o
);
  import tdcr_pkg::*;

  // ==========================================================
  // helpers
  // a software triple counts only when all three bits are set
  function automatic logic triple_off(input logic [2:0] d);
    return &d;
  endfunction
  // narrow mode leaves only the low 16 bits of the bus
  function automatic logic [31:0] bus_mask(input logic [31:0] d,
                                           input logic        nar);
    return nar ? {16'h0000, d[NARROW_W-1:0]} : {4'h0, d[BUS_W-1:0]};
  endfunction

  // ==========================================================
  // declarations
  tdcr_cfg_type       cfg;              // software configuration
  logic [9:0]         pin_raw;          // pins before synchronising
  logic [9:0]         pin_s;            // synchronised pins
  logic [9:0]         pin_q;            // previous synchronised pins
  logic               start_s;
  logic               start_q;
  logic               trig_rise;        // external processing trigger
  logic               sw_trig;          // one-cycle software trigger
  logic [TS_W-1:0]    stamp;            // free-running coarse time
  logic [TS_W-1:0]    start_stamp;      // reference start stamp
  logic               seen_start;       // a start has been taken
  logic               start_open;       // start channel accepting
  logic               start_ev;         // accepted start edge
  logic [3:0]         open_cnt;         // stop acceptance delay
  logic               stops_open;       // stops may be accepted
  logic [3:0]         pause_cnt;        // retrigger processing break
  logic               run_q;            // quiet mode run latch
  logic               proc_go;          // post-processing allowed
  logic [NCH-1:0]     stop_seen;        // a stop has been buffered
  logic [NCH-1:0]     hit_empty;
  logic [NCH-1:0]     busy;             // pipeline word in flight
  logic [TS_W-1:0]    if_dout   [NCH];
  logic [NCH-1:0]     if_empty;
  logic [NCH-1:0]     if_pop;
  logic [CNT_W-1:0]   stop_cnt  [NCH];
  logic               ack_q;            // answer cycle of a request
  logic [3:0]         reg_idx;
  logic               req;
  logic [31:0]        next_rdata;
  logic               oen_n_s;

  assign reg_idx = avs_address_i[ADDR_W-1:2];
  assign req     = avs_read_i | avs_write_i;

  // ==========================================================
  // pin synchronisers
  // order: start, stop1..0, start gate, stop gates, trigger, oe (inverted: reset = not driving)
  assign pin_raw = {~out_en_n_i, alu_trigger_i, stop_gate_pin_i,
                    start_gate_pin_i, diff_stop_input_i, start_pin_i};
  tdcr_sync #(
    .W (10)
  ) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (pin_raw),
    .q_o      (pin_s)
  );
  assign start_s = pin_s[0];
  assign start_q = pin_q[0];
  assign oen_n_s = ~pin_s[9];
  assign trig_rise = pin_s[8] & ~pin_q[8];

  // previous pin levels for edge detection
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pin_q <= '0;
    else
      pin_q <= pin_s;
  end

  // ==========================================================
  // coarse time base
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      stamp <= '0;
    else
      stamp <= stamp + 1'b1;
  end

  // ==========================================================
  // start channel
  // start edge gating
  assign start_ev = cfg.power & start_open & ~pin_s[3]
                  & ~triple_off(cfg.sw_dis[2:0])
                  & ((cfg.rise_en[0] & start_s & ~start_q)
                   | (cfg.fall_en[0] & ~start_s & start_q));

  // start reference, single-shot and retrigger break
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      seen_start  <= 1'b0;
      start_open  <= 1'b1;
      start_stamp <= '0;
      pause_cnt   <= '0;
    end
    else
    begin
      if (start_ev)
        seen_start <= 1'b1;
      if (start_ev & cfg.single)
        start_open <= 1'b0;
      if (start_ev & (~seen_start | cfg.retrig))
        start_stamp <= stamp;
      if (start_ev & seen_start & cfg.retrig)
        pause_cnt <= 4'(PAUSE_CYC);
      else if (pause_cnt != '0)
        pause_cnt <= pause_cnt - 1'b1;
    end
  end

  // ==========================================================
  // stop acceptance window
  // loaded on the first start; stops open once it has run down
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      open_cnt <= '0;
    else if (start_ev & ~seen_start)
      open_cnt <= 4'(STOP_OPEN_CYC);
    else if (open_cnt != '0)
      open_cnt <= open_cnt - 1'b1;
  end
  // stops wait for start when gated
  assign stops_open = ~cfg.wait_start
                    | (seen_start & (open_cnt == '0));

  // ==========================================================
  // processing trigger
  // quiet mode runs from a trigger until the hit buffers drain
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      run_q <= 1'b0;
    else if (trig_rise | sw_trig)
      run_q <= 1'b1;
    else if ((&hit_empty) & ~(|busy))
      run_q <= 1'b0;
  end
  // wait for a start and a stop
  assign proc_go = (cfg.quiet ? run_q : (seen_start & |stop_seen))
                 & (pause_cnt == '0);

  // ==========================================================
  // per-channel capture and processing
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      logic             s_now;          // synchronised stop level
      logic             s_old;          // previous stop level
      logic             rise_ok;
      logic             fall_ok;
      logic             hit_push;
      logic [TS_W-1:0]  hit_dout;
      logic             hit_full;
      logic             hit_pop;
      logic [TS_W-1:0]  result;         // offset-corrected interval
      logic             if_full;
      logic [$clog2(IF_DEP):0] if_count;

      assign s_now = pin_s[1+ch];
      assign s_old = pin_q[1+ch];
      // pin gate per edge, software triple
      // enable set and no disable active
      assign rise_ok = cfg.rise_en[1+ch] & ~pin_s[4+2*ch]
                     & ~triple_off(cfg.sw_dis[3*ch+3 +: 3]);
      assign fall_ok = cfg.fall_en[1+ch] & ~pin_s[5+2*ch]
                     & ~triple_off(cfg.sw_dis[3*ch+3 +: 3]);
      // both enables clear means no hits
      assign hit_push = cfg.power & stops_open
                      & ((rise_ok & s_now & ~s_old)
                       | (fall_ok & ~s_now & s_old));

      // count raw rising edges of powered input
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          stop_cnt[ch] <= '0;
        else if (cfg.power & s_now & ~s_old)
          stop_cnt[ch] <= stop_cnt[ch] + 1'b1;
      end

      // stop seen latch for non-quiet start condition
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          stop_seen[ch] <= 1'b0;
        else if (hit_push)
          stop_seen[ch] <= 1'b1;
      end

      // at least 32 hits, overflow drops
      tdcr_fifo #(
        .W     (TS_W),
        .DEPTH (HIT_DEP)
      ) u_hit (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .push_i   (hit_push),
        .din_i    (stamp),
        .pop_i    (hit_pop),
        .dout_o   (hit_dout),
        .count_o  (),
        .empty_o  (hit_empty[ch]),
        .full_o   (hit_full)
      );

      // one word per two cycles, stalls on full
      assign hit_pop = proc_go & ~hit_empty[ch] & ~busy[ch] & ~if_full;

      // subtraction stage, result held in flops
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          busy[ch] <= 1'b0;
          result   <= '0;
        end
        else
        begin
          busy[ch] <= hit_pop;
          if (hit_pop)
            result <= hit_dout - start_stamp
                    + TS_W'(cfg.offset * OFF_SCALE);
        end
      end

      tdcr_fifo #(
        .W     (TS_W),
        .DEPTH (IF_DEP)
      ) u_out (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .push_i   (busy[ch]),
        .din_i    (result),
        .pop_i    (if_pop[ch]),
        .dout_o   (if_dout[ch]),
        .count_o  (if_count),
        .empty_o  (if_empty[ch]),
        .full_o   (if_full)
      );

      assign buffer_empty_flag_o[ch] = if_empty[ch];
      assign buffer_level_flag_o[ch] =
        (if_count >= ($clog2(IF_DEP)+1)'(cfg.fill));
    end
  endgenerate

  // ==========================================================
  // bus handshake
  // one wait state: the answer comes in the cycle after the request
  assign avs_waitrequest_o = req & ~ack_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // buffers popped at 8 and 9
  assign if_pop[0] = avs_read_i & ack_q & (reg_idx == REG_FIFO0);
  assign if_pop[1] = avs_read_i & ack_q & (reg_idx == REG_FIFO1);

  // ==========================================================
  // register writes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg     <= '0;
      sw_trig <= 1'b0;
    end
    else
    begin
      sw_trig <= 1'b0;
      if (avs_write_i & ack_q)
      begin
        case (reg_idx)
          REG_ENABLE:
          begin
            cfg.rise_en <= avs_writedata_i[EN_RISE_LSB +: 3];
            cfg.fall_en <= avs_writedata_i[EN_FALL_LSB +: 3];
          end
          REG_DISABLE:
            cfg.sw_dis <= avs_writedata_i[8:0];
          REG_START:
          begin
            cfg.offset     <= avs_writedata_i[OFF_LSB +: OFF_W];
            cfg.retrig     <= avs_writedata_i[RETRIG_BIT];
            cfg.single     <= avs_writedata_i[SINGLE_BIT];
            cfg.wait_start <= avs_writedata_i[WAIT_BIT];
          end
          REG_LEVEL:
          begin
            cfg.fill  <= avs_writedata_i[FILL_LSB +: FILL_W];
            cfg.power <= avs_writedata_i[POWER_BIT];
          end
          REG_MODE:
          begin
            cfg.quiet <= avs_writedata_i[QUIET_BIT];
            sw_trig   <= avs_writedata_i[TRIG_BIT];
          end
          // narrow bus only for the exact code
          REG_WIDTH:
            cfg.narrow <= (avs_writedata_i == WIDTH16_CODE);
          default:
            cfg <= cfg;
        endcase
      end
    end
  end

  // ==========================================================
  // read mux, unmapped addresses read zero
  always_comb
  begin
    next_rdata = '0;
    case (reg_idx)
      REG_ENABLE:
      begin
        next_rdata[EN_RISE_LSB +: 3] = cfg.rise_en;
        next_rdata[EN_FALL_LSB +: 3] = cfg.fall_en;
      end
      REG_DISABLE:
        next_rdata[8:0] = cfg.sw_dis;
      REG_START:
      begin
        next_rdata[OFF_LSB +: OFF_W] = cfg.offset;
        next_rdata[RETRIG_BIT]       = cfg.retrig;
        next_rdata[SINGLE_BIT]       = cfg.single;
        next_rdata[WAIT_BIT]         = cfg.wait_start;
      end
      REG_LEVEL:
      begin
        next_rdata[FILL_LSB +: FILL_W] = cfg.fill;
        next_rdata[POWER_BIT]          = cfg.power;
      end
      REG_FIFO0:
        next_rdata = bus_mask(32'(if_dout[0]), cfg.narrow);
      REG_FIFO1:
        next_rdata = bus_mask(32'(if_dout[1]), cfg.narrow);
      REG_COUNT:
      begin
        next_rdata[0 +: CNT_W]        = stop_cnt[0];
        next_rdata[CNT1_LSB +: CNT_W] = stop_cnt[1];
      end
      REG_MODE:
        next_rdata[QUIET_BIT] = cfg.quiet;
      REG_WIDTH:
        next_rdata = cfg.narrow ? WIDTH16_CODE : '0;
      default:
        next_rdata = '0;
    endcase
  end

  // read data captured in the request cycle, stands in the answer
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_readdata_o <= '0;
    else if (avs_read_i & ~ack_q)
      avs_readdata_o <= next_rdata;
  end

  // ==========================================================
  // parallel data bus
  // holds the last buffer word taken; stale between reads
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      dbus_o <= '0;
    else if (|if_pop)
      dbus_o <= BUS_W'(next_rdata);
  end
  assign dbus_oe_o = ~oen_n_s;

  assign diff_buffer_power_o = cfg.power;

endmodule

// file: bench/tdcr_monitor.sv
/* tdcr_monitor: port checks of tdcr_top.
   assumes a bind into tdcr_top and one clock. */
`timescale 1ns/1ps
module tdcr_monitor
  import tdcr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        out_en_n_i,
  input wire logic        dbus_oe_o,
  input wire logic        diff_buffer_power_o,
  input wire logic [1:0]  buffer_empty_flag_o,
  input wire logic [1:0]  buffer_level_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ======
  // shadow threshold; flags follow it in the same cycle
  wire        req = avs_read_i | avs_write_i;
  wire        acc = avs_write_i & !avs_waitrequest_o & (avs_address_i[5:2] == REG_LEVEL);
  logic [8:0] fill;
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      fill <= 9'h0;
    else if (acc)
      fill <= avs_writedata_i[8:0];
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("request not held off");
  a_wait_once: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("second wait state");
  a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait without request");
  a_power_set: assert property (acc |=> diff_buffer_power_o == $past(avs_writedata_i[16]))
    else $error("power bit not applied");
  a_power_hold: assert property (!acc |=> $stable(diff_buffer_power_o))
    else $error("power bit moved");
  a_level_zero: assert property (fill == 9'h0 |-> &buffer_level_flag_o)
    else $error("level low at zero threshold");
  a_level_empty: assert property (fill != 9'h0 && $stable(fill) |->
    !(|(buffer_level_flag_o & buffer_empty_flag_o))) else $error("level high while empty");
  a_oe_on: assert property (!out_en_n_i [*4] |-> dbus_oe_o)
    else $error("bus not driven");
endmodule
bind tdcr_top tdcr_monitor tdcr_monitor_inst (.clk_i, .arst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .out_en_n_i,
  .dbus_oe_o, .diff_buffer_power_o, .buffer_empty_flag_o, .buffer_level_flag_o);

// file: bench/tdcr_hit_src.sv
/* tdcr_hit_src: start and stop pulse source at the pins.
   assumes shot is called just after a rising clock edge. */
`timescale 1ns/1ps
module tdcr_hit_src (
  input  wire logic       clk_i,
  output logic            start_o,
  output logic      [1:0] stop_o
);
  initial
  begin
    start_o = 1'b0;
    stop_o  = 2'b00;
  end
  // one start per shot
  // stops follow gap cycles later; start held gap cycles, stops held three cycles
  task automatic shot(input int gap, input logic [1:0] m);
    start_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
    start_o <= 1'b0;
    stop_o  <= m;
    repeat (3) @(posedge clk_i);
    stop_o  <= 2'b00;
  endtask
endmodule

// file: bench/test_tdcr_two_channel_stop_capture.sv
/* test_tdcr_two_channel_stop_capture: self-checking bench of tdcr_top.
   assumes tdcr_hit_src drives the pins and tdcr_monitor is bound. */
`timescale 1ns/1ps
module test_tdcr_two_channel_stop_capture;
  import tdcr_pkg::*;
  logic        clk_i = 0, arst_n_i = 0, rd = 0, wr = 0, oen_n = 1, start;
  logic [31:0] wd = 0, q;
  logic [5:0]  adr = 0;
  logic [3:0]  gate = 0;
  logic [1:0]  stop;
  wire  [31:0] rdat;
  wire  [1:0]  ef, lf;
  wire         wq, pwr;
  wire  [27:0] dbus;
  int          fails = 0, n_checks = 0;
  always #50 clk_i = ~clk_i;
  tdcr_hit_src tdcr_hit_src_inst (.clk_i, .start_o(start), .stop_o(stop));
  tdcr_top tdcr_top_inst (.clk_i, .arst_n_i, .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .start_pin_i(start), .diff_stop_input_i(stop), .start_gate_pin_i(1'b0),
    .stop_gate_pin_i(gate), .alu_trigger_i(1'b0), .out_en_n_i(oen_n), .dbus_o(dbus),
    .dbus_oe_o(), .diff_buffer_power_o(pwr), .buffer_empty_flag_o(ef),
    .buffer_level_flag_o(lf));
  task automatic summarize;
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] ix, input logic [31:0] d);
    adr <= {ix, 2'b00};
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_i); while (wq !== 1'b0);
    q = rdat;
    wr <= 0;
    rd <= 0;
    @(posedge clk_i);
  endtask
  task automatic t_meas;
    chk({pwr, lf, ef}, 5'h0f);
    bus(1, REG_LEVEL, 32'h1_0001);
    bus(1, REG_ENABLE, 32'h7);
    bus(1, REG_START, 32'h4);
    tdcr_hit_src_inst.shot(5, 2'b11);
    while (ef !== 2'b00) @(posedge clk_i);
    chk({pwr, lf}, 3'h7);
    bus(0, REG_FIFO0, 0);
    chk(q[22:0], 23'(5 + 4 * OFF_SCALE));
    bus(0, REG_FIFO1, 0);
    chk(q[22:0], 23'(5 + 4 * OFF_SCALE));
    chk(dbus, 23'(5 + 4 * OFF_SCALE));
    chk(ef, 2'b11);
  endtask
  task automatic t_gate;
    gate <= 4'h1;
    oen_n <= 0;
    bus(1, REG_DISABLE, 32'h1c0);
    tdcr_hit_src_inst.shot(5, 2'b11);
    repeat (20) @(posedge clk_i);
    chk(ef, 2'b11);
    bus(0, REG_COUNT, 0);
    chk(q[15:0], 16'h0202);
    oen_n <= 1;
  endtask
  task automatic t_width;
    bus(1, REG_WIDTH, WIDTH16_CODE);
    bus(0, REG_WIDTH, 0);
    chk(q, WIDTH16_CODE);
  endtask
  task automatic t_retrig;
    gate <= 4'h0;
    bus(1, REG_DISABLE, 0);
    bus(1, REG_START, 32'h4_03e8);
    tdcr_hit_src_inst.shot(5, 2'b11);
    while (ef !== 2'b00) @(posedge clk_i);
    bus(0, REG_FIFO0, 0);
    chk(q[22:0] - 23'(1000 * OFF_SCALE), 5);
    bus(0, REG_FIFO1, 0);
    chk(q[22:0], 23'(5 + 1000 * OFF_SCALE));
  endtask
  task automatic t_quiet;
    bus(1, REG_MODE, 32'h1);
    tdcr_hit_src_inst.shot(5, 2'b11);
    repeat (20) @(posedge clk_i);
    chk(ef, 2'b11);
    bus(1, REG_MODE, 32'h3);
    while (ef !== 2'b00) @(posedge clk_i);
    bus(0, REG_FIFO0, 0);
    chk(q[22:0], 23'(5 + 1000 * OFF_SCALE));
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1;
    @(posedge clk_i);
    t_meas();
    t_gate();
    t_retrig();
    t_quiet();
    t_width();
    summarize();
  end
  initial
  begin
    #300000;
    fails++;
    summarize();
  end
endmodule
